// ### hw/gpcn_pkg.sv
`default_nettype none

package gpcn_pkg;

    // port geometry
    localparam int PORT_W = 16;
    localparam int CN_W = 31;
    localparam int CN_LO_W = 16;
    localparam int CN_HI_W = CN_W - CN_LO_W;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_DIRECTION = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_OUT_LATCH = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PIN_VALUE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_ANALOG_CFG = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CN_EN_LO = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CN_EN_HI = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_PU_EN_LO = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_PU_EN_HI = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_CN_STATUS = 8'h24;

    // which port bits exist, which have an analog function
    localparam logic [PORT_W-1:0] IMPL_MASK = 16'h7FFF;
    localparam logic [PORT_W-1:0] ANALOG_MASK = 16'h003F;

    // reset values
    localparam logic [PORT_W-1:0] RST_DIRECTION = IMPL_MASK;
    localparam logic [PORT_W-1:0] RST_OUT_LATCH = 16'h0000;
    localparam logic [PORT_W-1:0] RST_OPEN_DRAIN = 16'h0000;
    localparam logic [PORT_W-1:0] RST_ANALOG_CFG = 16'h0000;
    localparam logic [CN_W-1:0] RST_CN_EN = 31'h00000000;
    localparam logic [CN_W-1:0] RST_PU_EN = 31'h00000000;

    // change status field
    localparam int CN_FLAG_BIT = 0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } gpcn_bus_req_t;

    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oeN;
    } gpcn_pad_drive_t;

endpackage : gpcn_pkg

`default_nettype wire

// ### hw/gpcn_port.sv
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module gpcn_port (
    input wire logic clk,
    input wire logic sys_rst,
    input wire gpcn_pkg::gpcn_bus_req_t busReq,
    output logic [gpcn_pkg::DATA_W-1:0] busRdata,
    input wire logic [gpcn_pkg::PORT_W-1:0] padIn,
    output gpcn_pkg::gpcn_pad_drive_t padDrive,
    input wire logic [gpcn_pkg::PORT_W-1:0] periphEnable,
    input wire logic [gpcn_pkg::PORT_W-1:0] periphDriving,
    input wire logic [gpcn_pkg::PORT_W-1:0] periphOut,
    output logic [gpcn_pkg::PORT_W-1:0] periphIn,
    output logic [gpcn_pkg::PORT_W-1:0] analogSwitch,
    output logic [gpcn_pkg::PORT_W-1:0] digitalBufEn,
    input wire logic [gpcn_pkg::CN_W-1:0] changeInputPin,
    output logic [gpcn_pkg::CN_W-1:0] pullupEn,
    output logic changeIrq,
    output logic changeWake
);
    import gpcn_pkg::*;

    logic [PORT_W-1:0] direction_reg, direction_next;
    logic [PORT_W-1:0] output_latch_reg, output_latch_next;
    logic [PORT_W-1:0] open_drain_ctrl_reg, open_drain_ctrl_next;
    logic [PORT_W-1:0] analog_pin_cfg_reg, analog_pin_cfg_next;
    logic [CN_W-1:0] cnEn_reg, cnEn_next;
    logic [CN_W-1:0] puEn_reg, puEn_next;
    logic [CN_W-1:0] cnSample_reg, cnSample_next;
    logic cnFlag_reg, cnFlag_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [PORT_W-1:0] padMeta_reg, padSync_reg;
    logic [CN_W-1:0] cnMeta_reg, cnSync_reg;

    logic [PORT_W-1:0] periphOwn;
    logic [PORT_W-1:0] portDrive;
    logic [PORT_W-1:0] analogMode;
    logic [PORT_W-1:0] pinValue;
    logic cnEvent;
    logic cnClear;

    // pin and change inputs cross in through two flops each
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            padMeta_reg <= '0;
            padSync_reg <= '0;
            cnMeta_reg <= '0;
            cnSync_reg <= '0;
        end else begin
            padMeta_reg <= padIn;
            padSync_reg <= padMeta_reg;
            cnMeta_reg <= changeInputPin;
            cnSync_reg <= cnMeta_reg;
        end
    end

    // ownership and pad control, combinational from registers and peripheral inputs
    always_comb begin
        periphOwn = periphEnable & periphDriving & IMPL_MASK;
        // idle peripheral leaves the pin to the port
        portDrive = ~direction_reg & ~periphOwn & IMPL_MASK;
        analogMode = ~analog_pin_cfg_reg & ANALOG_MASK;
        analogSwitch = analogMode;
        digitalBufEn = ~analogMode & IMPL_MASK;
        // analog pins read low, missing bits read zero
        pinValue = padSync_reg & ~analogMode & IMPL_MASK;
        // loop-through: the port's own drive never reaches the peripheral
        periphIn = padSync_reg & ~portDrive & ~analogMode;
    end

    // per-pin output stage; open drain only pulls low on port-driven pins, a peripheral owner drives both levels
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_pad
            always_comb begin
                if (periphOwn[gi]) begin
                    padDrive.out[gi] = periphOut[gi];
                    padDrive.oeN[gi] = 1'b0;
                end else if (portDrive[gi] && open_drain_ctrl_reg[gi]) begin
                    padDrive.out[gi] = 1'b0;
                    padDrive.oeN[gi] = output_latch_reg[gi];
                end else begin
                    padDrive.out[gi] = output_latch_reg[gi];
                    padDrive.oeN[gi] = ~portDrive[gi];
                end
            end
        end
    endgenerate

    // change detection; the wake path is pure logic so it works unclocked
    always_comb begin
        cnEvent = |((cnSync_reg ^ cnSample_reg) & cnEn_reg);
        changeWake = |((changeInputPin ^ cnSample_reg) & cnEn_reg);
        pullupEn = puEn_reg;
        changeIrq = cnFlag_reg;
        busRdata = rdata_reg;
    end

    // register writes, change flag and read data
    always_comb begin
        direction_next = direction_reg;
        output_latch_next = output_latch_reg;
        open_drain_ctrl_next = open_drain_ctrl_reg;
        analog_pin_cfg_next = analog_pin_cfg_reg;
        cnEn_next = cnEn_reg;
        puEn_next = puEn_reg;
        cnClear = 1'b0;
        rdata_next = '0;
        if (busReq.wr) begin
            case (busReq.addr)
                OFS_DIRECTION: direction_next = busReq.wdata[PORT_W-1:0] & IMPL_MASK;
                OFS_OUT_LATCH: output_latch_next = busReq.wdata[PORT_W-1:0] & IMPL_MASK;
                OFS_PIN_VALUE: output_latch_next = busReq.wdata[PORT_W-1:0] & IMPL_MASK;
                OFS_OPEN_DRAIN: open_drain_ctrl_next = busReq.wdata[PORT_W-1:0] & IMPL_MASK;
                OFS_ANALOG_CFG: analog_pin_cfg_next = busReq.wdata[PORT_W-1:0] & ANALOG_MASK;
                OFS_CN_EN_LO: cnEn_next[CN_LO_W-1:0] = busReq.wdata[CN_LO_W-1:0];
                OFS_CN_EN_HI: cnEn_next[CN_W-1:CN_LO_W] = busReq.wdata[CN_HI_W-1:0];
                OFS_PU_EN_LO: puEn_next[CN_LO_W-1:0] = busReq.wdata[CN_LO_W-1:0];
                OFS_PU_EN_HI: puEn_next[CN_W-1:CN_LO_W] = busReq.wdata[CN_HI_W-1:0];
                OFS_CN_STATUS: cnClear = busReq.wdata[CN_FLAG_BIT];
                default: ;
            endcase
        end
        if (busReq.rd) begin
            case (busReq.addr)
                OFS_DIRECTION: rdata_next[PORT_W-1:0] = direction_reg;
                OFS_OUT_LATCH: rdata_next[PORT_W-1:0] = output_latch_reg;
                OFS_PIN_VALUE: rdata_next[PORT_W-1:0] = pinValue;
                OFS_OPEN_DRAIN: rdata_next[PORT_W-1:0] = open_drain_ctrl_reg;
                OFS_ANALOG_CFG: rdata_next[PORT_W-1:0] = analog_pin_cfg_reg;
                OFS_CN_EN_LO: rdata_next[CN_LO_W-1:0] = cnEn_reg[CN_LO_W-1:0];
                OFS_CN_EN_HI: rdata_next[CN_HI_W-1:0] = cnEn_reg[CN_W-1:CN_LO_W];
                OFS_PU_EN_LO: rdata_next[CN_LO_W-1:0] = puEn_reg[CN_LO_W-1:0];
                OFS_PU_EN_HI: rdata_next[CN_HI_W-1:0] = puEn_reg[CN_W-1:CN_LO_W];
                OFS_CN_STATUS: rdata_next[CN_FLAG_BIT] = cnFlag_reg;
                default: rdata_next = '0;
            endcase
        end
        // a new change beats a same-cycle clear
        cnFlag_next = (cnFlag_reg & ~cnClear) | cnEvent;
        cnSample_next = cnSync_reg;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            direction_reg <= RST_DIRECTION;
            output_latch_reg <= RST_OUT_LATCH;
            open_drain_ctrl_reg <= RST_OPEN_DRAIN;
            analog_pin_cfg_reg <= RST_ANALOG_CFG;
            cnEn_reg <= RST_CN_EN;
            puEn_reg <= RST_PU_EN;
            cnSample_reg <= '0;
            cnFlag_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            direction_reg <= direction_next;
            output_latch_reg <= output_latch_next;
            open_drain_ctrl_reg <= open_drain_ctrl_next;
            analog_pin_cfg_reg <= analog_pin_cfg_next;
            cnEn_reg <= cnEn_next;
            puEn_reg <= puEn_next;
            cnSample_reg <= cnSample_next;
            cnFlag_reg <= cnFlag_next;
            rdata_reg <= rdata_next;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_periph_owns;
        (periphOwn & padDrive.oeN) == '0 && ((padDrive.out ^ periphOut) & periphOwn) == '0;
    endproperty
    a_periph_owns: assert property (p_periph_owns) else $error("peripheral lost its pin");

    property p_port_drives;
        ((portDrive & ~open_drain_ctrl_reg) & (padDrive.oeN | (padDrive.out ^ output_latch_reg)))
            == '0;
    endproperty
    a_port_drives: assert property (p_port_drives) else $error("port not driving latch");

    property p_no_loop;
        (periphIn & portDrive) == '0;
    endproperty
    a_no_loop: assert property (p_no_loop) else $error("port output looped to peripheral");

    property p_input_released;
        ((direction_reg & ~periphOwn) & ~padDrive.oeN) == '0;
    endproperty
    a_input_released: assert property (p_input_released) else $error("input pin driven");

    property p_latch_write;
        busReq.wr && (busReq.addr == OFS_OUT_LATCH || busReq.addr == OFS_PIN_VALUE)
            |=> output_latch_reg == ($past(busReq.wdata[PORT_W-1:0]) & IMPL_MASK);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch write lost");

    property p_pin_read;
        busReq.rd && busReq.addr == OFS_PIN_VALUE |=> busRdata[PORT_W-1:0] == $past(pinValue);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

    property p_unimpl_zero;
        ((direction_reg | output_latch_reg | pinValue) & ~IMPL_MASK) == '0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("missing bit not zero");

    property p_open_drain;
        ((portDrive & open_drain_ctrl_reg) & ~padDrive.oeN & padDrive.out) == '0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

    property p_analog_low;
        busReq.rd && busReq.addr == OFS_PIN_VALUE
            |=> (busRdata[PORT_W-1:0] & $past(analogMode)) == '0;
    endproperty
    a_analog_low: assert property (p_analog_low) else $error("analog pin read high");

    property p_change_flag;
        cnEvent |=> changeIrq ##1 (changeIrq || $past(cnClear));
    endproperty
    a_change_flag: assert property (p_change_flag) else $error("change flag not raised");

    property p_change_clear;
        cnClear && !cnEvent |=> !changeIrq;
    endproperty
    a_change_clear: assert property (p_change_clear) else $error("change flag stuck");

    property p_wake;
        changeWake |-> ##[0:3] (changeIrq || !changeWake || cnEn_reg != $past(cnEn_reg));
    endproperty
    a_wake: assert property (p_wake) else $error("wake without flag");

    // reset value check must run while reset is high, so it opts out of the default disable
    property p_reset_input;
        disable iff (1'b0)
        sys_rst |=> direction_reg == RST_DIRECTION && analog_pin_cfg_reg == RST_ANALOG_CFG;
    endproperty
    a_reset_input: assert property (p_reset_input) else $error("reset value lost");

    // register writes land one cycle after the strobe
    property p_dir_write;
        busReq.wr && busReq.addr == OFS_DIRECTION
            |=> direction_reg == ($past(busReq.wdata[PORT_W-1:0]) & IMPL_MASK);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");

    property p_cn_en_write;
        busReq.wr && busReq.addr == OFS_CN_EN_HI
            |=> cnEn_reg[CN_W-1:CN_LO_W] == $past(busReq.wdata[CN_HI_W-1:0]);
    endproperty
    a_cn_en_write: assert property (p_cn_en_write) else $error("enable write lost");

    property p_pullup_write;
        busReq.wr && busReq.addr == OFS_PU_EN_LO
            |=> pullupEn[CN_LO_W-1:0] == $past(busReq.wdata[CN_LO_W-1:0]);
    endproperty
    a_pullup_write: assert property (p_pullup_write) else $error("pull-up write lost");

    // read data stand one cycle only, so a stale word never passes for a fresh one
    property p_rdata_idle;
        !busReq.rd |=> busRdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");

    property p_analog_quiet;
        (periphIn & analogMode) == '0;
    endproperty
    a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin leaked");

    // main scenarios worth seeing
    c_change: cover property (cnEvent ##1 changeIrq ##[1:20] cnClear);
    c_pin_write: cover property (busReq.wr && busReq.addr == OFS_PIN_VALUE ##1 portDrive != '0);
    c_periph_own: cover property (periphOwn != '0 && direction_reg != IMPL_MASK);
    c_wake: cover property (changeWake ##1 changeIrq);
    c_open_drain: cover property ((portDrive & open_drain_ctrl_reg) != '0);

endmodule : gpcn_port

`default_nettype wire

// ### dv/gpcn_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module gpcn_pin_model (
    input wire logic clk,
    input wire gpcn_pkg::gpcn_pad_drive_t padDrive,
    input wire logic [gpcn_pkg::PORT_W-1:0] extLevel,
    input wire logic [gpcn_pkg::CN_W-1:0] pullupEn,
    input wire logic [gpcn_pkg::CN_W-1:0] cnDrv,
    input wire logic [gpcn_pkg::CN_W-1:0] cnExt,
    output logic [gpcn_pkg::PORT_W-1:0] padIn,
    output logic [gpcn_pkg::CN_W-1:0] changeInputPin
);
    import gpcn_pkg::*;
    logic floatPat = 1'b0;
    // floating lines wander so a stale level never passes for a real one
    always @(posedge clk) floatPat <= ~floatPat;
    // a driven pad shows the chip level, a released one the board level
    assign padIn = (~padDrive.oeN & padDrive.out) | (padDrive.oeN & extLevel);
    // weak pull-up holds an undriven change pin high
    assign changeInputPin = (cnDrv & cnExt) | (~cnDrv & (pullupEn | {CN_W{floatPat}}));
endmodule : gpcn_pin_model

`default_nettype wire

// ### dv/gpio_port_with_change_notify_tb.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_port_with_change_notify_tb;
    import gpcn_pkg::*;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    gpcn_bus_req_t busReq = '0;
    logic [DATA_W-1:0] busRdata;
    gpcn_pad_drive_t padDrive;
    logic [PORT_W-1:0] padIn, periphIn, analogSwitch, digitalBufEn;
    logic [PORT_W-1:0] periphEnable = '0, periphDriving = '0, periphOut = '0, extLevel = '0;
    logic [CN_W-1:0] changeInputPin, pullupEn, cnExt = '0;
    logic [CN_W-1:0] cnDrv = '1;
    logic changeIrq, changeWake;
    int bad_count = 0;
    int check_count = 0;

    always #25 clk = ~clk;

    gpcn_port gpcn_port_inst (.clk(clk), .sys_rst(sysRst), .busReq(busReq),
        .busRdata(busRdata), .padIn(padIn), .padDrive(padDrive),
        .periphEnable(periphEnable), .periphDriving(periphDriving), .periphOut(periphOut),
        .periphIn(periphIn), .analogSwitch(analogSwitch), .digitalBufEn(digitalBufEn),
        .changeInputPin(changeInputPin), .pullupEn(pullupEn), .changeIrq(changeIrq),
        .changeWake(changeWake));
    gpcn_pin_model gpcn_pin_model_inst (.clk(clk), .padDrive(padDrive), .extLevel(extLevel),
        .pullupEn(pullupEn), .cnDrv(cnDrv), .cnExt(cnExt), .padIn(padIn),
        .changeInputPin(changeInputPin));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    // one comparison, reported at once on mismatch
    task automatic chk(input string what, input logic [DATA_W-1:0] e,
        input logic [DATA_W-1:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // single-cycle write strobe
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rdchk(input string what, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] e);
        @(posedge clk);
        busReq <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1 chk(what, e, busRdata);
    endtask : rdchk

    // bounded wait; an expired wait ends the run
    task automatic wait_irq(input string what);
        int n;
        // look just after the edge, once the flag has settled
        for (n = 0; n < 8 && changeIrq !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk(what, 32'h00000001, 32'(changeIrq));
        if (n == 8) print_verdict();
    endtask : wait_irq

    task automatic t_reset();
        rdchk("dir", OFS_DIRECTION, 32'h00007FFF);
        rdchk("latch", OFS_OUT_LATCH, 32'h00000000);
        rdchk("acfg", OFS_ANALOG_CFG, 32'h00000000);
        chk("oeN", 32'(IMPL_MASK), 32'(padDrive.oeN & IMPL_MASK));
        chk("aswitch", 32'h0000003F, 32'(analogSwitch));
        chk("pullup", 32'h00000000, 32'(pullupEn));
    endtask : t_reset

    task automatic t_regs();
        wr(OFS_OUT_LATCH, 32'hFFFFFFFF);
        rdchk("latch mask", OFS_OUT_LATCH, 32'h00007FFF);
        wr(OFS_PIN_VALUE, 32'h00001234);
        rdchk("pin wr", OFS_OUT_LATCH, 32'h00001234);
        wr(8'h3C, 32'hFFFFFFFF);
        rdchk("unmapped", 8'h3C, 32'h00000000);
        wr(OFS_DIRECTION, 32'hFFFF0000);
        rdchk("dir hi", OFS_DIRECTION, 32'h00000000);
        repeat (3) @(posedge clk);
        chk("out", 32'h00001234, 32'(padDrive.out & IMPL_MASK));
        chk("oeN out", 32'h00000000, 32'(padDrive.oeN & IMPL_MASK));
        rdchk("pin drv", OFS_PIN_VALUE, 32'h00001200);
    endtask : t_regs

    task automatic t_analog();
        extLevel <= 16'h5A5A;
        wr(OFS_DIRECTION, 32'h0000FFFF);
        repeat (3) @(posedge clk);
        rdchk("pin ana", OFS_PIN_VALUE, 32'h00005A40);
        wr(OFS_ANALOG_CFG, 32'hFFFFFFFF);
        rdchk("acfg mask", OFS_ANALOG_CFG, 32'h0000003F);
        rdchk("pin dig", OFS_PIN_VALUE, 32'h00005A5A);
        chk("aswitch", 32'h00000000, 32'(analogSwitch));
        chk("dbuf", 32'h00007FFF, 32'(digitalBufEn));
    endtask : t_analog

    task automatic t_odrain();
        wr(OFS_DIRECTION, 32'h00000000);
        wr(OFS_OUT_LATCH, 32'h00000005);
        wr(OFS_OPEN_DRAIN, 32'h00000003);
        #1 chk("od out", 32'h00000004, 32'(padDrive.out[3:0]));
        chk("od oeN", 32'h00000001, 32'(padDrive.oeN[3:0]));
        wr(OFS_OPEN_DRAIN, 32'h00000000);
    endtask : t_odrain

    task automatic t_periph();
        wr(OFS_OUT_LATCH, 32'h00000200);
        periphEnable <= 16'h0300;
        periphDriving <= 16'h0100;
        periphOut <= 16'h0100;
        repeat (3) @(posedge clk);
        chk("pe out", 32'h00000003, 32'(padDrive.out[9:8]));
        chk("pe oeN", 32'h00000000, 32'(padDrive.oeN[9:8]));
        chk("pe in", 32'h00000001, 32'(periphIn[9:8]));
        rdchk("pe pin", OFS_PIN_VALUE, 32'h00000300);
        periphDriving <= 16'h0000;
        @(posedge clk);
        #1 chk("pe idle", 32'h00000002, 32'(padDrive.out[9:8]));
    endtask : t_periph

    task automatic t_change();
        wr(OFS_DIRECTION, 32'h0000FFFF);
        wr(OFS_CN_EN_LO, 32'h00000020);
        wr(OFS_CN_EN_HI, 32'h00004000);
        wr(OFS_CN_STATUS, 32'h00000001);
        cnExt[3] <= 1'b1;
        repeat (6) @(posedge clk);
        chk("masked", 32'h00000000, 32'(changeIrq));
        cnExt[5] <= 1'b1;
        #1 chk("wake", 32'h00000001, 32'(changeWake));
        wait_irq("irq lo");
        chk("wake idle", 32'h00000000, 32'(changeWake));
        wr(OFS_CN_STATUS, 32'h00000001);
        #1 chk("clear", 32'h00000000, 32'(changeIrq));
        cnExt[30] <= 1'b1;
        wait_irq("irq hi");
        rdchk("status", OFS_CN_STATUS, 32'h00000001);
        wr(OFS_PU_EN_LO, 32'h000000FF);
        wr(OFS_PU_EN_HI, 32'hFFFFFFFF);
        #1 chk("pullup", 32'h7FFF00FF, 32'(pullupEn));
    endtask : t_change

    // a reset in mid-run must undo everything set so far
    task automatic t_rerst();
        @(posedge clk);
        sysRst <= 1'b1;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        #1 chk("irq rst", 32'h00000000, 32'(changeIrq));
        rdchk("dir rst", OFS_DIRECTION, 32'h00007FFF);
        rdchk("pu rst", OFS_PU_EN_HI, 32'h00000000);
    endtask : t_rerst

    initial begin
        repeat (16) @(posedge clk);
        sysRst <= 1'b0;
        t_reset();
        t_regs();
        t_analog();
        t_odrain();
        t_periph();
        t_change();
        t_rerst();
        print_verdict();
    end
endmodule : gpio_port_with_change_notify_tb

`default_nettype wire
